// file: gcs_cfg.svh
`ifndef GCS_CFG_SVH
`define GCS_CFG_SVH
// Reset defaults of software-held bits
`define GCS_RST_REF_FAIL_PIN_EN   1'b0
`define GCS_RST_LOCK_PIN_EN       1'b0
`define GCS_RST_IRQ_LOS_SEL       1'b0
`define GCS_RST_GP4_DIR           1'b0
// Synchroniser depth for pin inputs
`define GCS_SYNC_STAGES           2
// Least hold of reset low, in master clock cycles
`define GCS_RST_HOLD_CYC          2
// Clocks after release before straps are caught, so the synchronisers hold the pin again
`define GCS_STRAP_WAIT            2'h2
`endif

// file: gcs_pkg.sv
`default_nettype none
package gcs_pkg;
	typedef enum logic [1:0] {GCS_IRQ_REQ, GCS_IRQ_GPO} gcs_irq_role_t;
	typedef enum logic {GCS_RATE_SDH, GCS_RATE_SONET} gcs_rate_t;
	typedef enum logic {GCS_PAIR_3_5, GCS_PAIR_4_6} gcs_pair_t;
endpackage
`default_nettype wire

// file: gcs_sync.sv
`timescale 1ns/10ps
`default_nettype none
module gcs_sync
(
	input  wire logic i_ref_clk,
	input  wire logic i_nrst,
	input  wire logic i_async,
	output logic      o_sync
);
	logic meta_q;
	logic meta_d;
	logic sync_d;

	always_comb
	begin
		meta_d = i_async;
		sync_d = meta_q;
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			meta_q <= 1'b0;
			o_sync <= 1'b0;
		end
		else
		begin
			meta_q <= meta_d;
			o_sync <= sync_d;
		end
	end
endmodule // gcs_sync
`default_nettype wire

// file: gcs_top.sv
// Summary of operation
// - Reset low returns all state to defaults and holds it while low.
// - Reset release captures fast source switch into external switching enable.
// - With switching enabled, source switch picks pair three/five or four/six.
// - Reset release loads rate strap into rate family and both frequency selects.
// - After reset the strap pin is GPIO with direction, output value, status.
// - Reference-fail pin mirrors latched fail when enabled, else low.
// - Lock pin shows primary DPLL lock when enabled, else low.
// - Select bit picks interrupt mode (0, default) or loss-of-reference mode (1).
// - Interrupt mode applies configured polarity and push-pull or open-drain drive.
// - Interrupt mode may instead be a software-driven general output.
// - Loss mode drives real-time unlatched activity of the selected reference.
// - Reference fail sets from monitoring of the selected input and clears only on a clear request.
`timescale 1ns/10ps
`include "gcs_cfg.svh"
`default_nettype none
module gcs_top
(
	input  wire logic             i_ref_clk,
	input  wire logic             i_nrst,
	input  wire logic             i_fast_source_switch_in,
	input  wire logic             i_rate_strap_in,
	output logic                  o_rate_strap_out,
	output logic                  o_rate_strap_oe,
	input  wire logic             i_gp4_direction,
	input  wire logic             i_gp4_output_value,
	output logic                  o_gp4_pin_state,
	output logic                  o_external_switching_enable,
	output logic                  o_rate_family,
	output logic                  o_digital_freq1_select,
	output logic                  o_digital_freq2_select,
	output gcs_pkg::gcs_pair_t    o_pair_select,
	input  wire logic             i_sel_ref_active,
	input  wire logic             i_sel_ref_freq_ok,
	input  wire logic             i_ref_fail_clear,
	output logic                  o_ref_fail,
	input  wire logic             i_ref_fail_pin_enable,
	output logic                  o_ref_fail_pin,
	input  wire logic             i_primary_dpll_locked,
	input  wire logic             i_lock_pin_enable,
	output logic                  o_lock_pin,
	input  wire logic             i_irq_los_select,
	input  wire logic             i_irq_active_high,
	input  wire logic             i_irq_open_drain,
	input  wire logic             i_irq_as_gpo,
	input  wire logic             i_irq_gpo_value,
	input  wire logic             i_irq_pending,
	output logic                  o_irq_out,
	output logic                  o_irq_oe
);
	import gcs_pkg::*;

	logic sw_s;
	logic gp_s;
	logic act_s;
	logic lock_s;

	// Pin inputs pass two flops before use
	gcs_sync u_sync_sw (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_async(i_fast_source_switch_in), .o_sync(sw_s));
	gcs_sync u_sync_gp (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_async(i_rate_strap_in), .o_sync(gp_s));
	gcs_sync u_sync_act (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_async(i_sel_ref_active), .o_sync(act_s));
	gcs_sync u_sync_lk (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_async(i_primary_dpll_locked), .o_sync(lock_s));

	// Synchronisers are cleared by reset, so wait until they carry the pin again
	logic       armed_q, armed_d;
	logic [1:0] wait_q, wait_d;
	logic       ext_q, ext_d;
	logic       rate_q, rate_d;
	logic       dig1_q, dig1_d;
	logic       dig2_q, dig2_d;
	gcs_pair_t  pair_q, pair_d;
	logic       gpst_q, gpst_d;
	logic       gpo_q, gpo_d;
	logic       gpoe_q, gpoe_d;

	always_comb
	begin
		armed_d = armed_q || (wait_q == `GCS_STRAP_WAIT);
		wait_d  = (wait_q == `GCS_STRAP_WAIT) ? wait_q : wait_q + 2'h1;
		ext_d   = ext_q;
		rate_d  = rate_q;
		dig1_d  = dig1_q;
		dig2_d  = dig2_q;
		pair_d  = pair_q;
		gpst_d  = gp_s;
		gpo_d   = 1'b0;
		gpoe_d  = 1'b0;
		if (!armed_q)
		begin
			if (wait_q == `GCS_STRAP_WAIT)
			begin
				ext_d  = sw_s;
				rate_d = gp_s;
				dig1_d = gp_s;
				dig2_d = gp_s;
			end
		end
		else
		begin
			gpo_d  = i_gp4_output_value;
			gpoe_d = i_gp4_direction;
			if (ext_q)
				pair_d = sw_s ? GCS_PAIR_4_6 : GCS_PAIR_3_5;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			armed_q <= 1'b0;
			wait_q  <= 2'h0;
			ext_q   <= 1'b0;
			rate_q  <= 1'b0;
			dig1_q  <= 1'b0;
			dig2_q  <= 1'b0;
			pair_q  <= GCS_PAIR_3_5;
			gpst_q  <= 1'b0;
			gpo_q   <= 1'b0;
			gpoe_q  <= `GCS_RST_GP4_DIR;
		end
		else
		begin
			armed_q <= armed_d;
			wait_q  <= wait_d;
			ext_q   <= ext_d;
			rate_q  <= rate_d;
			dig1_q  <= dig1_d;
			dig2_q  <= dig2_d;
			pair_q  <= pair_d;
			gpst_q  <= gpst_d;
			gpo_q   <= gpo_d;
			gpoe_q  <= gpoe_d;
		end
	end

	assign o_external_switching_enable = ext_q;
	assign o_rate_family               = rate_q;
	assign o_digital_freq1_select      = dig1_q;
	assign o_digital_freq2_select      = dig2_q;
	assign o_pair_select               = pair_q;
	assign o_gp4_pin_state             = gpst_q;
	assign o_rate_strap_out            = gpo_q;
	assign o_rate_strap_oe             = gpoe_q;

	// Status pins
	logic fail_q, fail_d;
	logic fpin_q, fpin_d;
	logic lpin_q, lpin_d;
	logic irq_q, irq_d;
	logic irqoe_q, irqoe_d;
	logic fail_cond;
	logic lvl;

	always_comb
	begin
		fail_cond = !act_s || !i_sel_ref_freq_ok;
		// Set wins over a clear in the same cycle
		fail_d = fail_cond ? 1'b1 : (i_ref_fail_clear ? 1'b0 : fail_q);
		fpin_d = i_ref_fail_pin_enable ? fail_q : 1'b0;
		lpin_d = i_lock_pin_enable ? lock_s : 1'b0;
		lvl    = i_irq_as_gpo ? i_irq_gpo_value : i_irq_pending;
		irq_d   = 1'b0;
		irqoe_d = 1'b1;
		if (i_irq_los_select)
		begin
			irq_d   = act_s;
			irqoe_d = 1'b1;
		end
		else if (i_irq_open_drain)
		begin
			// Open drain never drives high; pulls low whenever the pin should read low
			irq_d   = 1'b0;
			irqoe_d = i_irq_active_high ? !lvl : lvl;
		end
		else
		begin
			irq_d   = i_irq_active_high ? lvl : !lvl;
			irqoe_d = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_nrst)
		begin
			fail_q  <= 1'b0;
			fpin_q  <= 1'b0;
			lpin_q  <= 1'b0;
			irq_q   <= 1'b0;
			irqoe_q <= 1'b0;
		end
		else
		begin
			fail_q  <= fail_d;
			fpin_q  <= fpin_d;
			lpin_q  <= lpin_d;
			irq_q   <= irq_d;
			irqoe_q <= irqoe_d;
		end
	end

	assign o_ref_fail     = fail_q;
	assign o_ref_fail_pin = fpin_q;
	assign o_lock_pin     = lpin_q;
	assign o_irq_out      = irq_q;
	assign o_irq_oe       = irqoe_q;

	a_fail_pin_low: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		!i_ref_fail_pin_enable |=> !o_ref_fail_pin) else $error("fail pin high while disabled");
	a_fail_pin_mirror: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		i_ref_fail_pin_enable |=> o_ref_fail_pin == $past(fail_q)) else $error("fail pin not mirroring");
	a_lock_pin_follow: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		1'b1 |=> o_lock_pin == ($past(i_lock_pin_enable) && $past(lock_s))) else $error("lock pin wrong");
	a_los_mode_drive: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		i_irq_los_select |=> o_irq_oe && o_irq_out == $past(act_s)) else $error("loss mode wrong");
	a_strap_capture: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		!armed_q && wait_q == `GCS_STRAP_WAIT |=> ext_q == $past(sw_s) && rate_q == $past(gp_s)
		&& dig2_q == rate_q) else $error("strap miss");
	a_strap_hold: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		armed_q |=> $stable(rate_q) && $stable(ext_q)) else $error("strap changed");
	a_pair_select: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		armed_q && ext_q |=> o_pair_select == ($past(sw_s) ? GCS_PAIR_4_6 : GCS_PAIR_3_5)) else $error("pair wrong");
	a_pair_frozen: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		armed_q && !ext_q |=> $stable(o_pair_select)) else $error("pair moved");
	a_fail_sets: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		fail_cond |=> o_ref_fail) else $error("fail not set");
	a_gpio_dir: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		armed_q |=> o_rate_strap_oe == $past(i_gp4_direction)) else $error("gpio dir wrong");
	a_od_never_high: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		!i_irq_los_select && i_irq_open_drain |=> !o_irq_out) else $error("open drain drove high");
endmodule // gcs_top
`default_nettype wire

// file: gcs_board.sv
`timescale 1ns/10ps
`default_nettype none
module gcs_board
(
	input  wire logic i_dev_oe,
	input  wire logic i_dev_val,
	input  wire logic i_brd_en,
	input  wire logic i_brd_val,
	output logic      o_pin
);
	// Pull-down wins when nobody drives
	assign o_pin = i_dev_oe ? i_dev_val : (i_brd_en ? i_brd_val : 1'b0);
endmodule // gcs_board
`default_nettype wire

// file: tb_global_control_status_pins.sv
`timescale 1ns/10ps
`default_nettype none
module tb_global_control_status_pins;
	import gcs_pkg::*;
	logic clk = 0, nrst = 0, sw = 1, dir = 0, gv = 0, act = 1, fok = 1, clr = 0, fen = 0;
	logic lck = 0, len = 0, loss_of_reference = 0, ahi = 0, od = 0, gpo = 0, gpv = 0, pend = 0, drv = 1, dv = 1;
	logic pin, s_out, s_oe, gst, ext, rate, f1, f2, fail, fpin, lpin, iout, ioe, a, b, c;
	logic [1:0] e;
	gcs_pair_t pair;
	int n_mismatch = 0, check_count = 0;
	always #12.5 clk = ~clk;
	gcs_board u_brd (.i_dev_oe(s_oe), .i_dev_val(s_out), .i_brd_en(drv), .i_brd_val(dv), .o_pin(pin));
	gcs_top DUT (
		.i_ref_clk(clk),
		.i_nrst(nrst),
		.i_fast_source_switch_in(sw),
		.i_rate_strap_in(pin),
		.o_rate_strap_out(s_out),
		.o_rate_strap_oe(s_oe),
		.i_gp4_direction(dir),
		.i_gp4_output_value(gv),
		.o_gp4_pin_state(gst),
		.o_external_switching_enable(ext),
		.o_rate_family(rate),
		.o_digital_freq1_select(f1),
		.o_digital_freq2_select(f2),
		.o_pair_select(pair),
		.i_sel_ref_active(act),
		.i_sel_ref_freq_ok(fok),
		.i_ref_fail_clear(clr),
		.o_ref_fail(fail),
		.i_ref_fail_pin_enable(fen),
		.o_ref_fail_pin(fpin),
		.i_primary_dpll_locked(lck),
		.i_lock_pin_enable(len),
		.o_lock_pin(lpin),
		.i_irq_los_select(loss_of_reference),
		.i_irq_active_high(ahi),
		.i_irq_open_drain(od),
		.i_irq_as_gpo(gpo),
		.i_irq_gpo_value(gpv),
		.i_irq_pending(pend),
		.o_irq_out(iout),
		.o_irq_oe(ioe)
	);
	task chk(input string nm, input logic seen, input logic exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %b seen %b", nm, exp, seen);
		end
	endtask
	task step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Returns {oe, out}; open drain only pulls low
	function logic [1:0] irq_exp(input logic ah, input logic odr, input logic g, input logic v, input logic p);
		logic as;
		as = g ? v : p;
		return odr ? {as ^ ah, 1'b0} : {1'b1, as ~^ ah};
	endfunction
	task do_reset(input logic s, input logic d);
		nrst = 0;
		drv = 1;
		dv = d;
		sw = s;
		step(3);
		chk("irq_oe_rst", ioe, 1'b0);
		chk("fail_rst", fail, 1'b0);
		nrst = 1;
		step(4);
		chk("ext_sw", ext, s);
		chk("rate", rate, d);
		chk("freq1", f1, d);
		chk("freq2", f2, d);
	endtask
	initial
	begin
		void'($urandom(10415));
		do_reset(1'b1, 1'b1);
		dv = 0;
		step(5);
		chk("rate_kept", rate, 1'b1);
		repeat (6)
		begin
			a = 1'($urandom);
			sw = a;
			step(5);
			chk("pair", pair, a);
		end
		repeat (8)
		begin
			{a, b, c} = 3'($urandom);
			dir = a;
			gv = b;
			drv = !a;
			dv = c;
			step(5);
			chk("gp_oe", s_oe, a);
			chk("gp_state", gst, a ? b : c);
		end
		dir = 0;
		fok = 0;
		fen = 1;
		step(3);
		chk("fail", fail, 1'b1);
		chk("fail_pin", fpin, 1'b1);
		fen = 0;
		step(2);
		chk("fail_pin_off", fpin, 1'b0);
		fok = 1;
		clr = 1;
		step(1);
		clr = 0;
		step(2);
		chk("fail_clr", fail, 1'b0);
		act = 0;
		step(5);
		chk("fail_act", fail, 1'b1);
		act = 1;
		do_reset(1'b0, 1'b0);
		sw = 1;
		step(5);
		chk("pair_fixed", pair, 1'b0);
		repeat (8)
		begin
			{a, b} = 2'($urandom);
			lck = a;
			len = b;
			step(5);
			chk("lock_pin", lpin, a & b);
		end
		repeat (32)
		begin
			{ahi, od, gpo, gpv, pend} = 5'($urandom);
			step(3);
			e = irq_exp(ahi, od, gpo, gpv, pend);
			chk("irq_oe", ioe, e[1]);
			chk("irq_out", iout, e[0]);
		end
		loss_of_reference = 1;
		act = 0;
		step(5);
		chk("los_low", iout, 1'b0);
		chk("los_oe", ioe, 1'b1);
		act = 1;
		step(5);
		chk("los_follow", iout, 1'b1);
		print_verdict();
	end
	initial
	begin
		#200000;
		n_mismatch++;
		print_verdict();
	end
endmodule // tb_global_control_status_pins
`default_nettype wire
